// >>> sim/fspa_pulse_src.sv
// upstream pulse source model: free running associated clock and one pulse pin
`timescale 1ns/100ps
module fspa_pulse_src
  import fspa_pkg::*;
(
  input  wire logic [SEL_W-1:0]  sel,    // pin that carries the pulse
  input  wire logic              level,  // requested pulse level
  output logic                   lclk,   // associated input clock
  output logic      [NUM_IN-1:0] pins    // pulse pins, unchosen ones stay low
);
  logic [NUM_IN-1:0] pin_q = '0;  // pins start low, so no unknown level reaches the capture
  // start offset keeps the link phase unrelated to the system clock
  initial begin
    lclk = 1'b0;
    #3.3;
    forever #62.5 lclk = ~lclk;  // 125 ns period
  end
  // level moves only on link edges, so every pulse lasts whole link cycles
  always @(posedge lclk) pin_q <= NUM_IN'(level) << sel;
  assign pins = pin_q;
endmodule : fspa_pulse_src

// >>> sim/tb_frame_sync_pulse_aligner.sv
// bench for the pulse aligner: bus tasks, pulse stimulus, status model
`timescale 1ns/100ps
module tb_frame_sync_pulse_aligner;
  import fspa_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic associated_input_clock, aligned_output_pulse, crystal_loop_reference;
  logic crystal_reference_input = 1'b0;
  logic [NUM_IN-1:0] input_pulse_signal;
  logic [NUM_OUT-1:0] aligned_output_clock;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, crystal_reference_frequency, q, v, ctl;
  logic [3:0] s_axi_wstrb = 4'hF, s;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, level = 1'b0, en, fa;
  logic [SEL_W-1:0] sel = '0;
  int err_total = 0, checks = 0, seed = 54540, cnt = 0;
  localparam int DIV = 4, WID = 1;  // output half period and pulse width used by the model
  logic [NUM_OUT-1:0] rl;           // role bits written for the output check
  always #5 clock = ~clock;
  fspa_top dut (.clock, .rst_n, .associated_input_clock, .input_pulse_signal,
    .aligned_output_clock, .aligned_output_pulse, .crystal_reference_input,
    .crystal_loop_reference, .crystal_reference_frequency, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  fspa_pulse_src src (.sel, .level, .lclk(associated_input_clock), .pins(input_pulse_signal));
  // verdict and end of run
  task automatic complete_run;
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // one comparison, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one AXI4-Lite write or read; handshakes judged at the settled mid-cycle level
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic ah, wh, ar, fin;
    @(posedge clock);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
    fin = 1'b0;
    for (int n = 0; n < 50 && !fin; n++) begin
      @(negedge clock);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      ar = s_axi_arvalid & s_axi_arready;
      fin = w ? (s_axi_bvalid === 1'b1) : (s_axi_rvalid === 1'b1);
      q = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge clock);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
    end
    {s_axi_bready, s_axi_rready} <= 2'b00;
    // a slave that never answers ends the run
    if (!fin) begin
      err_total++;
      complete_run();
    end
  endtask : bus
  // status read against the model's count and sticky flag
  task automatic st(input logic f);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(q, {cnt[15:0], 15'h0, f});
  endtask : st
  // outputs after one level change: an alignment gives a pulse of 2*DIV*WID cycles,
  // with every pin high at first and the clock-role pins low after DIV cycles
  task automatic outs(input logic exp);
    int n, k;
    n = 0;
    for (k = 0; k < 100 && aligned_output_pulse !== 1'b1; k++) @(negedge clock);
    if (exp) chk(aligned_output_clock, {NUM_OUT{1'b1}});
    while (n < 100 && aligned_output_pulse === 1'b1) begin
      if (n == DIV) chk(aligned_output_clock, 32'(rl));
      n++;
      @(negedge clock);
    end
    chk(n, exp ? 2 * DIV * WID : 0);
  endtask : outs
  // reset values and writable bits of the first six registers
  logic [31:0] rv [6] = '{32'h0, 32'h1, 32'h8, 32'h1, 32'h0, 32'h0};
  logic [31:0] mk [6] = '{32'hFFFF_FFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFF, 32'hFFFF_FFFF};
  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    st(1'b0);
    // reset values, then random write and masked read back
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ADDR_W'(4 * i), 32'h0);
      chk(q, rv[i]);
      v = $random(seed);
      bus(1'b1, ADDR_W'(4 * i), v);
      bus(1'b0, ADDR_W'(4 * i), 32'h0);
      chk(q, v & mk[i]);
    end
    chk(crystal_reference_frequency, v);
    // unmapped place: refused both ways
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
    chk(32'(r), 32'(RESP_SLVERR));
    bus(1'b0, 8'h1C, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    // fixed output setup, integer related; a long period keeps free-running pulses away
    rl = NUM_OUT'($random(seed));
    bus(1'b1, OFS_DIVIDER, DIV);
    bus(1'b1, OFS_PERIOD, 32'hFFFF);
    bus(1'b1, OFS_WIDTH, WID);
    bus(1'b1, OFS_ROLE, 32'(rl));
    // modes: frame/sync by rising/falling edge, then disabled; random pin each time
    for (int m = 0; m < 5; m++) begin
      en = m < 4;
      fa = m[1];
      s = 4'($random(seed));
      sel <= s;
      crystal_reference_input <= 1'($random(seed));
      ctl = {24'h0, s, ~en, fa, m[0], en};
      bus(1'b1, OFS_CONTROL, ctl);
      chk(32'(crystal_loop_reference), 32'(crystal_reference_input & ctl[3]));
      bus(1'b1, OFS_STATUS, 32'h1);
      repeat (40) @(posedge clock);
      level <= 1'b1;
      outs(en & !fa);
      cnt += 32'(en & !fa);
      st(en & !fa);
      level <= 1'b0;
      outs(en & fa);
      cnt += 32'(en & fa);
      st(en);
    end
    complete_run();
  end
endmodule : tb_frame_sync_pulse_aligner

// >>> src/fspa_link_edge.sv
// pulse capture on the associated input clock, marks alignment edges
`timescale 1ns/100ps
module fspa_link_edge
  import fspa_pkg::*;
(
  input  wire logic              associated_input_clock,  // link clock
  input  wire logic              rst_n,                   // async, active low
  input  wire logic [NUM_IN-1:0] input_pulse_signal,      // candidate pulse pins
  fspa_link_if.link              lnk                      // config in, event out
);
  // config is static in use, so two flops per bit suffice
  logic [SEL_W+2:0] cfg_s1;        // first stage, read only by cfg_s2
  logic [SEL_W+2:0] cfg_s2;        // settled config
  logic [NUM_IN-1:0] pin_s1;       // first stage of every pin, read only by pin_s2
  logic [NUM_IN-1:0] pin_s2;       // settled pulse levels
  logic             pin_prev;      // previous level of the chosen pin
  logic             armed;         // frame mode waits one clock edge
  logic             toggle;        // event toggle toward the core
  wire  [SEL_W-1:0] sel     = cfg_s2[SEL_W+2:3];
  wire              sync_m  = cfg_s2[1];
  wire              falling = cfg_s2[2];
  wire              enable  = cfg_s2[0];
  // any pin may serve as the pulse input; picked after the synchroniser so
  // no half-settled pin level ever reaches the edge logic
  wire              pin_now = pin_s2[sel];
  // pick the marking edge; any pulse rate is accepted, no rate filter
  wire              rise    = pin_now & ~pin_prev;
  wire              fall    = ~pin_now & pin_prev;
  wire              edge_hit = enable & (falling ? fall : rise);

  // config crossing
  always_ff @(posedge associated_input_clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_s1 <= '0;
      cfg_s2 <= '0;
    end else begin
      cfg_s1 <= {lnk.cfg_sel, lnk.cfg_falling, lnk.cfg_sync, lnk.cfg_enable};
      cfg_s2 <= cfg_s1;
    end
  end

  // pulse pin synchroniser and history
  always_ff @(posedge associated_input_clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1   <= '0;
      pin_s2   <= '0;
      pin_prev <= 1'b0;
    end else begin
      pin_s1   <= input_pulse_signal;
      pin_s2   <= pin_s1;
      pin_prev <= pin_now;
    end
  end

  // sync mode: the pulse edge itself aligns; frame mode: the next clock edge
  always_ff @(posedge associated_input_clock or negedge rst_n) begin
    if (!rst_n) begin
      armed  <= 1'b0;
      toggle <= 1'b0;
    end else begin
      armed <= edge_hit & ~sync_m;
      if ((edge_hit & sync_m) | armed) begin
        toggle <= ~toggle;
      end
    end
  end
  assign lnk.align_toggle = toggle;

  // frame mode: flip one link edge after the marking edge is seen
  sequence s_frame_hit;
    edge_hit && !sync_m;
  endsequence
  sequence s_sync_hit;
    edge_hit && sync_m;
  endsequence
  AST_FRAME_NEXT_EDGE: assert property (
    @(posedge associated_input_clock) disable iff (!rst_n)
    s_frame_hit |=> $stable(toggle) ##1 (toggle != $past(toggle)))
    else $error("frame mode did not align on the next clock edge");
  AST_SYNC_SAME_EDGE: assert property (
    @(posedge associated_input_clock) disable iff (!rst_n)
    s_sync_hit |=> (toggle != $past(toggle)))
    else $error("sync mode did not align on the pulse edge");
  AST_EDGE_POLARITY: assert property (
    @(posedge associated_input_clock) disable iff (!rst_n)
    (enable && falling && rise && !armed) |=> $stable(toggle))
    else $error("rising edge used while falling edge selected");
endmodule : fspa_link_edge

// >>> src/fspa_link_if.sv
// link-side bundle between the core and the pulse capture module
`timescale 1ns/100ps
interface fspa_link_if;
  import fspa_pkg::*;
  logic             cfg_enable;    // alignment allowed
  logic             cfg_sync;      // sync mode when high
  logic             cfg_falling;   // falling edge marks
  logic [SEL_W-1:0] cfg_sel;       // chosen pulse input
  logic             align_toggle;  // flips once per alignment edge
  modport core (output cfg_enable, cfg_sync, cfg_falling, cfg_sel, input align_toggle);
  modport link (input cfg_enable, cfg_sync, cfg_falling, cfg_sel, output align_toggle);
endinterface : fspa_link_if

// >>> src/fspa_pkg.sv
// shared constants for the frame and sync pulse aligner
package fspa_pkg;
  // counts of pins and widths
  localparam int NUM_IN  = 16;                 // selectable pulse inputs
  localparam int NUM_OUT = 12;                 // outputs with a clock or pulse role
  localparam int SEL_W   = 4;                  // width of the input select
  localparam int CNT_W   = 16;                 // width of divider and width counters
  localparam int ADDR_W  = 8;                  // register bus address width
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL  = 8'h00;  // loop_pulse_control
  localparam logic [ADDR_W-1:0] OFS_DIVIDER  = 8'h04;  // loop_primary_divider
  localparam logic [ADDR_W-1:0] OFS_PERIOD   = 8'h08;  // output clocks per pulse
  localparam logic [ADDR_W-1:0] OFS_WIDTH    = 8'h0C;  // pulse width in output clocks
  localparam logic [ADDR_W-1:0] OFS_ROLE     = 8'h10;  // per output: 1 pulse, 0 clock
  localparam logic [ADDR_W-1:0] OFS_CRYSTAL_REFERENCE_FREQUENCY  = 8'h14;  // crystal_reference_frequency
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h18;  // alignment status
  // control field positions
  localparam int CTL_ENABLE  = 0;              // loop_pulse_align_enable
  localparam int CTL_SYNC    = 1;              // 1 sync mode, 0 frame mode
  localparam int CTL_FALLING = 2;              // 1 falling edge marks
  localparam int CTL_XO_USE  = 3;              // crystal reference fitted
  localparam int CTL_SEL_LSB = 4;              // input select field
  // status field positions
  localparam int STS_ALIGNED = 0;              // sticky, write one to clear
  localparam int STS_CNT_LSB = 16;             // count of alignments
  // reset values
  localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
  localparam logic [CNT_W-1:0] RST_DIVIDER = 16'h0001;
  localparam logic [CNT_W-1:0] RST_PERIOD  = 16'h0008;
  localparam logic [CNT_W-1:0] RST_WIDTH   = 16'h0001;
  localparam logic [31:0] RST_CRYSTAL_REFERENCE_FREQUENCY = 32'h0000_0000;
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // smallest pulse the source may send, in ns, and its count at 100 MHz
  localparam int PULSE_MIN_NS  = 10;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : fspa_pkg

// >>> src/fspa_top.sv
// frame and sync pulse aligner: register slave, output dividers, alignment
//
// Overview of operation
// - frame edge makes next clock edge align
// - rising edge marks unless falling selected
// - all frame pulse rates accepted
// - output rates free; integer relation aligns
// - outputs align to first edge after pulse
// - enabled alignment shifts output phase
// - selectable output pulse widths
// - any input or output takes pulse role
// - sync mode aligns on pulse edge itself
// - sync uses rising edge unless falling selected
// - all sync pulse rates accepted
// - crystal input has no monitoring or alarm
// - optional crystal feeds loop, frequency declared
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module fspa_top
  import fspa_pkg::*;
(
  input  wire logic               clock,                        // system clock, 100 MHz
  input  wire logic               rst_n,                        // async, active low
  // link side
  input  wire logic               associated_input_clock,       // link clock
  input  wire logic [NUM_IN-1:0]  input_pulse_signal,           // frame or sync pins
  // outputs and crystal input
  output logic      [NUM_OUT-1:0] aligned_output_clock,         // per output, by role
  output logic                    aligned_output_pulse,         // pulse copy
  input  wire logic               crystal_reference_input,      // optional crystal
  output logic                    crystal_loop_reference,       // to the system loop
  output logic      [31:0]        crystal_reference_frequency,  // declared frequency
  // register bus
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic      [1:0]         s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic      [31:0]        s_axi_rdata,
  output logic      [1:0]         s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);
  // byte-lane merge for a write
  function automatic logic [31:0] fspa_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : fspa_merge

  // a zero count behaves as one, so dividers never stall
  function automatic logic [CNT_W-1:0] fspa_min1(input logic [CNT_W-1:0] v);
    return (v == '0) ? CNT_W'(1) : v;
  endfunction : fspa_min1

  // registers
  logic [31:0]        loop_pulse_control;   // enable, mode, edge, crystal, select
  logic [CNT_W-1:0]   loop_primary_divider; // half period of the output clock
  logic [CNT_W-1:0]   pulse_period;         // output clocks per output pulse
  logic [CNT_W-1:0]   pulse_width;          // high time in output clocks
  logic [NUM_OUT-1:0] out_role;             // 1 pulse, 0 clock
  logic               aligned_flag;         // sticky alignment seen
  logic [15:0]        align_count;          // alignments since reset

  // bus slave state
  logic               aw_hold;              // write address taken
  logic               w_hold;               // write data taken
  logic [ADDR_W-1:0]  aw_addr;              // held write address
  logic [31:0]        w_data;               // held write data
  logic [3:0]         w_strb;               // held strobes

  // output generator state
  logic [CNT_W-1:0]   div_cnt;              // system cycles into half period
  logic               clk_q;                // generated clock
  logic [CNT_W-1:0]   frame_cnt;            // output clocks into frame
  logic               pulse_q;              // generated pulse
  logic [2:0]         align_sync;           // toggle crossing, [0] read by [1] only

  fspa_link_if lnk ();                      // link bundle

  // config toward the link domain
  wire                align_enable = loop_pulse_control[CTL_ENABLE];
  assign lnk.cfg_enable  = align_enable;
  assign lnk.cfg_sync    = loop_pulse_control[CTL_SYNC];
  assign lnk.cfg_falling = loop_pulse_control[CTL_FALLING];
  assign lnk.cfg_sel     = loop_pulse_control[CTL_SEL_LSB +: SEL_W];

  fspa_link_edge u_link (
    .associated_input_clock (associated_input_clock),
    .rst_n                  (rst_n),
    .input_pulse_signal     (input_pulse_signal),
    .lnk                    (lnk)
  );

  // alignment event in the system domain
  wire                align_evt  = align_sync[2] ^ align_sync[1];
  wire                align_fire = align_evt & align_enable;

  // divider decode
  wire [CNT_W-1:0]    div_eff    = fspa_min1(loop_primary_divider);
  wire [CNT_W-1:0]    per_eff    = fspa_min1(pulse_period);
  // >= rather than == so a count left above a newly lowered divider or period
  // wraps at once instead of running on to the counter's overflow
  wire                half_done  = (div_cnt >= div_eff - CNT_W'(1));
  wire                rise_now   = half_done & ~clk_q;
  wire                frame_end  = (frame_cnt >= per_eff - CNT_W'(1));
  wire [CNT_W-1:0]    next_frame = frame_end ? '0 : frame_cnt + CNT_W'(1);

  // bus decode
  wire                aw_take    = s_axi_awvalid & s_axi_awready;
  wire                w_take     = s_axi_wvalid & s_axi_wready;
  wire                wr_do      = aw_hold & w_hold & ~s_axi_bvalid;
  wire                ar_take    = s_axi_arvalid & s_axi_arready;
  wire                wr_ok      = (aw_addr == OFS_CONTROL) | (aw_addr == OFS_DIVIDER) |
                                   (aw_addr == OFS_PERIOD)  | (aw_addr == OFS_WIDTH)   |
                                   (aw_addr == OFS_ROLE)    | (aw_addr == OFS_CRYSTAL_REFERENCE_FREQUENCY) |
                                   (aw_addr == OFS_STATUS);
  wire                rd_ok      = (s_axi_araddr == OFS_CONTROL) |
                                   (s_axi_araddr == OFS_DIVIDER) |
                                   (s_axi_araddr == OFS_PERIOD)  |
                                   (s_axi_araddr == OFS_WIDTH)   |
                                   (s_axi_araddr == OFS_ROLE)    |
                                   (s_axi_araddr == OFS_CRYSTAL_REFERENCE_FREQUENCY) |
                                   (s_axi_araddr == OFS_STATUS);
  wire [31:0]         status_word = {align_count, 15'h0000, aligned_flag};
  wire [31:0]         rd_word =
    (s_axi_araddr == OFS_CONTROL) ? loop_pulse_control :
    (s_axi_araddr == OFS_DIVIDER) ? {16'h0000, loop_primary_divider} :
    (s_axi_araddr == OFS_PERIOD)  ? {16'h0000, pulse_period} :
    (s_axi_araddr == OFS_WIDTH)   ? {16'h0000, pulse_width} :
    (s_axi_araddr == OFS_ROLE)    ? {20'h00000, out_role} :
    (s_axi_araddr == OFS_CRYSTAL_REFERENCE_FREQUENCY) ? crystal_reference_frequency :
    (s_axi_araddr == OFS_STATUS)  ? status_word : 32'h0000_0000;
  wire [31:0]         wr_merge_ctl  = fspa_merge(loop_pulse_control, w_data, w_strb);
  wire [31:0]         wr_merge_div  = fspa_merge({16'h0000, loop_primary_divider},
                                                 w_data, w_strb);
  wire [31:0]         wr_merge_per  = fspa_merge({16'h0000, pulse_period}, w_data, w_strb);
  wire [31:0]         wr_merge_wid  = fspa_merge({16'h0000, pulse_width}, w_data, w_strb);
  wire [31:0]         wr_merge_role = fspa_merge({20'h00000, out_role}, w_data, w_strb);
  wire [31:0]         wr_merge_xo   = fspa_merge(crystal_reference_frequency, w_data,
                                                 w_strb);
  wire                clr_aligned   = wr_do & (aw_addr == OFS_STATUS) & w_strb[0] &
                                      w_data[STS_ALIGNED];

  // handshake outputs: one write and one read in flight
  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // crystal passes straight to the loop; no monitor, no alarm output
  assign crystal_loop_reference = crystal_reference_input &
                                  loop_pulse_control[CTL_XO_USE];

  // write channel capture, either order
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_hold <= 1'b0;
      end
      if (w_take) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_do) begin
        w_hold <= 1'b0;
      end
    end
  end

  // write response after both halves are in
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // configuration registers; any pin and any output can carry the pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loop_pulse_control          <= RST_CONTROL;
      loop_primary_divider        <= RST_DIVIDER;
      pulse_period                <= RST_PERIOD;
      pulse_width                 <= RST_WIDTH;
      out_role                    <= '0;
      crystal_reference_frequency <= RST_CRYSTAL_REFERENCE_FREQUENCY;
    end else if (wr_do) begin
      if (aw_addr == OFS_CONTROL) loop_pulse_control <= wr_merge_ctl;
      if (aw_addr == OFS_DIVIDER) loop_primary_divider <= wr_merge_div[CNT_W-1:0];
      if (aw_addr == OFS_PERIOD) pulse_period <= wr_merge_per[CNT_W-1:0];
      if (aw_addr == OFS_WIDTH) pulse_width <= wr_merge_wid[CNT_W-1:0];
      if (aw_addr == OFS_ROLE) out_role <= wr_merge_role[NUM_OUT-1:0];
      if (aw_addr == OFS_CRYSTAL_REFERENCE_FREQUENCY) crystal_reference_frequency <= wr_merge_xo;
    end
  end

  // status: a fresh alignment beats a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aligned_flag <= 1'b0;
      align_count  <= 16'h0000;
    end else begin
      if (align_fire) begin
        aligned_flag <= 1'b1;
        align_count  <= align_count + 16'h0001;
      end else if (clr_aligned) begin
        aligned_flag <= 1'b0;
      end
    end
  end

  // event toggle crossing from the link domain
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      align_sync <= 3'h0;
    end else begin
      align_sync <= {align_sync[1:0], lnk.align_toggle};
    end
  end

  // output clock and pulse; an alignment restarts both on a rising edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt   <= '0;
      clk_q     <= 1'b0;
      frame_cnt <= '0;
      pulse_q   <= 1'b0;
    end else if (align_fire) begin
      div_cnt   <= '0;
      clk_q     <= 1'b1;
      frame_cnt <= '0;
      pulse_q   <= (pulse_width != '0);
    end else if (half_done) begin
      div_cnt <= '0;
      clk_q   <= ~clk_q;
      if (rise_now) begin
        frame_cnt <= next_frame;
        pulse_q   <= (next_frame < pulse_width);
      end
    end else begin
      div_cnt <= div_cnt + CNT_W'(1);
    end
  end

  // output pins from flops, role picked per output
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aligned_output_clock <= '0;
      aligned_output_pulse <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        aligned_output_clock[i] <= out_role[i] ? pulse_q : clk_q;
      end
      aligned_output_pulse <= pulse_q;
    end
  end

  // checks
  sequence s_align;
    align_fire;
  endsequence
  AST_ALIGN_RISES_CLOCK: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_align |=> (clk_q && div_cnt == '0 && frame_cnt == '0))
    else $error("alignment did not restart the output clock");
  // with alignment off neither the clock phase nor the count may move
  AST_ALIGN_SHIFT_ONLY_ENABLED: assert property (
    @(posedge clock) disable iff (!rst_n)
    (!align_enable && !half_done) |=> ($stable(clk_q) && $stable(align_count)))
    else $error("output moved while alignment disabled");
  AST_PULSE_WIDTH_START: assert property (
    @(posedge clock) disable iff (!rst_n)
    (align_fire && pulse_width != '0) |=> pulse_q ##2 aligned_output_pulse)
    else $error("pulse did not start at alignment");
  AST_FRAME_WRAP: assert property (
    @(posedge clock) disable iff (!rst_n)
    (!align_fire && rise_now && frame_end) |=> (frame_cnt == '0))
    else $error("frame counter did not wrap at the period");
  AST_ROLE_SELECT: assert property (
    @(posedge clock) disable iff (!rst_n)
    ##1 (aligned_output_clock[0] == ($past(out_role[0]) ? $past(pulse_q) : $past(clk_q))))
    else $error("output 0 does not follow its role");
  AST_STICKY_SET_WINS: assert property (
    @(posedge clock) disable iff (!rst_n)
    (align_fire && clr_aligned) |=> aligned_flag)
    else $error("alignment lost to a clear");
  AST_CRYSTAL_PASS: assert property (
    @(posedge clock) disable iff (!rst_n)
    crystal_loop_reference == (crystal_reference_input && loop_pulse_control[CTL_XO_USE]))
    else $error("crystal path does not follow its enable");
  AST_BVALID_HOLD: assert property (
    @(posedge clock) disable iff (!rst_n)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before taken");
endmodule : fspa_top
